/* File: cgts_params.svh */
`ifndef CGTS_PARAMS_SVH
`define CGTS_PARAMS_SVH

// Cycle rates in cards per minute
`define CGTS_LIST_RATE_LO    80
`define CGTS_LIST_RATE_HI    100
`define CGTS_ACC_RATE        150
`define CGTS_CLK_HZ          10000000
// Cycles per machine cycle: clock Hz / rate, rounded down, then times 60
`define CGTS_PER_CYC(r)      ((`CGTS_CLK_HZ / (r)) * 60)
// Sensing index positions within a machine cycle (digits 9..0)
`define CGTS_DIGITS          10
`define CGTS_STEP_DIV        16
`define CGTS_CTRL_W          8
`define CGTS_NCNT            4
`define CGTS_CNT_W           16
`define CGTS_ID_W            8
`define CGTS_FIELDS          3

`endif

/* File: cgts_pkg.sv */
package cgts_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CARD,
    ST_TOTAL,
    ST_HEAD
  } cgts_state_t;
endpackage

/* File: cgts_sequencer.sv */
`timescale 1ns/1ps
`include "cgts_params.svh"

module cgts_sequencer #(
  parameter int unsigned LIST_CYC = `CGTS_PER_CYC(`CGTS_LIST_RATE_LO)
) (
  input  wire logic                                     sys_clk,      // 10 MHz clock
  input  wire logic                                     sys_rst,      // Sync reset, high
  input  wire logic                                     listWired,    // Every-cycle impulse wired to list
  input  wire logic                                     fastList,     // List rate 100 instead of 80
  input  wire logic                                     numericOnly,  // Numeric-only variant
  input  wire logic                                     threeStation, // Three-station variant
  input  wire logic                                     cardAt2,      // Card present at station two
  input  wire logic                                     cardAt3,      // Card present at station three
  input  wire logic                                     headCard,     // Station-three card is heading card
  input  wire logic [`CGTS_CTRL_W-1:0]                  ctrlAt2,      // Control field at station two
  input  wire logic [`CGTS_CTRL_W-1:0]                  ctrlAt3,      // Control field at station three
  input  wire logic [`CGTS_FIELDS*`CGTS_ID_W-1:0]       idHoles,      // Identifying columns, 3 fields
  input  wire logic [`CGTS_NCNT*4-1:0]                  qtyDigit,     // Quantity digit per counter
  input  wire logic [`CGTS_NCNT-1:0]                    qtyHole,      // Hole sensed in quantity column
  input  wire logic [`CGTS_NCNT-1:0]                    subtract,     // Counter subtracts
  input  wire logic [`CGTS_NCNT-1:0]                    printCmd,     // Counter prints on total
  output logic                                          feed,         // Card feed runs this cycle
  output logic                                          cycStrobe,    // Machine cycle start pulse
  output logic                                          barsUp,       // Type bars raised
  output logic                                          totalCycle,   // Program cycle running
  output logic                                          ctrlChange,   // Group total signal
  output logic [`CGTS_ID_W-1:0]                         idMagnets,    // Identifying type bar stops
  output logic [`CGTS_NCNT*`CGTS_CNT_W-1:0]             totMagnets    // Amount printed on total
);

  // Other rates scale from the list count, so a shortened list count shortens them all
  localparam int unsigned LIST_HI_CYC = (LIST_CYC * `CGTS_LIST_RATE_LO) / `CGTS_LIST_RATE_HI;
  localparam int unsigned ACC_CYC     = (LIST_CYC * `CGTS_LIST_RATE_LO) / `CGTS_ACC_RATE;

  // *****************************************************
  // State
  // *****************************************************
  typedef struct packed {
    cgts_pkg::cgts_state_t                  st;
    logic [31:0]                            tick;
    logic [31:0]                            len;
    logic                                   firstOfGroup;
    logic                                   endOfGroup;
    logic [1:0]                             field;
    logic                                   feed;
    logic                                   strobe;
    logic                                   barsUp;
    logic                                   total;
    logic                                   change;
    logic [`CGTS_ID_W-1:0]                  idMag;
    logic [`CGTS_NCNT*`CGTS_CNT_W-1:0]      cnt;
    logic [`CGTS_NCNT*`CGTS_CNT_W-1:0]      totMag;
  } cgts_regs_t;

  cgts_regs_t r;
  cgts_regs_t next_r;

  // Cycle length: printing uses list rate unless numeric-only, else accumulating rate
  function automatic logic [31:0] cycLen(input logic print, input logic fast, input logic num);
    if (!print || num)
      cycLen = 32'(ACC_CYC);
    else if (fast)
      cycLen = 32'(LIST_HI_CYC);
    else
      cycLen = 32'(LIST_CYC);
  endfunction

  logic differ;
  logic printCard;
  logic headNow;
  assign differ    = cardAt2 && cardAt3 && (ctrlAt2 != ctrlAt3);
  assign headNow   = threeStation && headCard;
  assign printCard = listWired || r.firstOfGroup;

  // *****************************************************
  // Sequencing
  // *****************************************************
  always_comb begin
    next_r        = r;
    next_r.strobe = 1'b0;
    next_r.tick   = r.tick + 32'd1;
    case (r.st)
      cgts_pkg::ST_IDLE: begin
        next_r.feed = 1'b0;
        if (cardAt3) begin
          next_r.st     = (threeStation && headCard) ? cgts_pkg::ST_HEAD : cgts_pkg::ST_CARD;
          next_r.field  = 2'd0;
          next_r.tick   = 32'd0;
          next_r.strobe = 1'b1;
          next_r.barsUp = printCard || headNow;
          next_r.len    = cycLen(printCard || headNow, fastList, numericOnly);
          // Compare now, while this card still sits at station three
          next_r.endOfGroup = differ;
          next_r.feed   = !(threeStation && headCard);
          // Same digit mapping regardless of cycle length
          for (int i = 0; i < `CGTS_NCNT; i++) begin
            if (qtyHole[i]) begin
              if (subtract[i])
                next_r.cnt[i*`CGTS_CNT_W +: `CGTS_CNT_W] = r.cnt[i*`CGTS_CNT_W +: `CGTS_CNT_W]
                  - `CGTS_CNT_W'(qtyDigit[i*4 +: 4]);
              else
                next_r.cnt[i*`CGTS_CNT_W +: `CGTS_CNT_W] = r.cnt[i*`CGTS_CNT_W +: `CGTS_CNT_W]
                  + `CGTS_CNT_W'(qtyDigit[i*4 +: 4]);
            end
          end
          next_r.idMag  = (printCard || headNow) ? idHoles[`CGTS_ID_W-1:0] : '0;
          next_r.firstOfGroup = 1'b0;
        end
      end
      cgts_pkg::ST_HEAD: begin
        next_r.feed = 1'b0;
        if (r.tick + 32'd1 >= r.len) begin
          next_r.tick   = 32'd0;
          next_r.strobe = 1'b1;
          next_r.field  = r.field + 2'd1;
          next_r.idMag  = idHoles[(r.field + 2'd1)*`CGTS_ID_W +: `CGTS_ID_W];
          // Last field runs as the card cycle itself, so the card feeds once
          if (r.field + 2'd1 == 2'(`CGTS_FIELDS - 1)) begin
            next_r.st   = cgts_pkg::ST_CARD;
            next_r.feed = 1'b1;
          end
        end
      end
      cgts_pkg::ST_CARD: begin
        next_r.feed = 1'b0;
        if (r.tick + 32'd1 >= r.len) begin
          next_r.barsUp = 1'b0;
          next_r.idMag  = '0;
          next_r.tick   = 32'd0;
          if (r.endOfGroup) begin
            next_r.st     = cgts_pkg::ST_TOTAL;
            next_r.change = 1'b1;
            next_r.total  = 1'b1;
            next_r.barsUp = 1'b1;
            next_r.strobe = 1'b1;
            next_r.len    = cycLen(1'b1, fastList, numericOnly);
            for (int i = 0; i < `CGTS_NCNT; i++)
              next_r.totMag[i*`CGTS_CNT_W +: `CGTS_CNT_W] = printCmd[i] ?
                r.cnt[i*`CGTS_CNT_W +: `CGTS_CNT_W] : '0;
          end else begin
            next_r.st = cgts_pkg::ST_IDLE;
          end
        end
      end
      cgts_pkg::ST_TOTAL: begin
        next_r.feed = 1'b0;
        if (r.tick + 32'd1 >= r.len) begin
          next_r.st           = cgts_pkg::ST_IDLE;
          next_r.total        = 1'b0;
          next_r.change       = 1'b0;
          next_r.barsUp       = 1'b0;
          next_r.totMag       = '0;
          next_r.cnt          = '0;
          next_r.firstOfGroup = 1'b1;
        end
      end
      default: next_r.st = cgts_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      r              <= '0;
      r.st           <= cgts_pkg::ST_IDLE;
      r.firstOfGroup <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign feed       = r.feed;
  assign cycStrobe  = r.strobe;
  assign barsUp     = r.barsUp;
  assign totalCycle = r.total;
  assign ctrlChange = r.change;
  assign idMagnets  = r.idMag;
  assign totMagnets = r.totMag;

  // *****************************************************
  // Checks
  // *****************************************************
  property p_total_zero;
    @(posedge sys_clk) disable iff (sys_rst)
      (r.st == cgts_pkg::ST_TOTAL && next_r.st == cgts_pkg::ST_IDLE) |=> (r.cnt == '0);
  endproperty
  a_total_zero: assert property (p_total_zero) else $error("counters not zeroed");

  property p_no_feed_total;
    @(posedge sys_clk) disable iff (sys_rst) totalCycle |-> !feed;
  endproperty
  a_no_feed_total: assert property (p_no_feed_total) else $error("feed during total");

  property p_print_rate;
    @(posedge sys_clk) disable iff (sys_rst)
      (cycStrobe && barsUp && !numericOnly) |-> (r.len == 32'(LIST_CYC) || r.len == 32'(LIST_HI_CYC));
  endproperty
  a_print_rate: assert property (p_print_rate) else $error("print cycle not at list rate");

  property p_acc_rate;
    @(posedge sys_clk) disable iff (sys_rst)
      (cycStrobe && !barsUp && r.st == cgts_pkg::ST_CARD) |-> (r.len == 32'(ACC_CYC));
  endproperty
  a_acc_rate: assert property (p_acc_rate) else $error("accumulate cycle wrong rate");

  property p_change_total;
    @(posedge sys_clk) disable iff (sys_rst) ctrlChange |-> totalCycle;
  endproperty
  a_change_total: assert property (p_change_total) else $error("change without total");

  property p_hold;
    @(posedge sys_clk) disable iff (sys_rst)
      (r.st == cgts_pkg::ST_IDLE && !cardAt3) |=> $stable(r.cnt);
  endproperty
  a_hold: assert property (p_hold) else $error("counter changed while idle");

endmodule

/* File: cgts_card_feed.sv */
`timescale 1ns/1ps
`include "cgts_params.svh"
module cgts_card_feed (
  input  wire logic                          sys_clk,  // Clock
  input  wire logic                          sys_rst,  // Restarts the deck
  input  wire logic                          feed,     // Advance one station
  output logic                               cardAt2,  // Card at two
  output logic                               cardAt3,  // Card at three
  output logic                               headCard, // Heading card at three
  output logic [`CGTS_CTRL_W-1:0]            ctrlAt2,  // Control, two
  output logic [`CGTS_CTRL_W-1:0]            ctrlAt3,  // Control, three
  output logic [`CGTS_FIELDS*`CGTS_ID_W-1:0] idHoles,  // Id fields, three
  output logic [`CGTS_NCNT*4-1:0]            qtyDigit  // Digits, three
);
  logic [36:0] deck [8] = '{default: '0};
  int          count = 0;
  int          pos   = 0;
  logic [36:0] c2;
  logic [36:0] c3;
  // ****************
  // Stations
  // ****************
  // Empty stations show an inverted pattern, never a held card
  assign cardAt3  = pos < count;
  assign cardAt2  = pos + 1 < count;
  assign c3       = cardAt3 ? deck[pos] : ~deck[7];
  assign c2       = cardAt2 ? deck[pos+1] : ~deck[7];
  assign headCard = c3[36];
  assign ctrlAt3  = c3[35:28];
  assign ctrlAt2  = c2[35:28];
  assign idHoles  = c3[27:4];
  assign qtyDigit = {4{c3[3:0]}};
  always @(negedge sys_clk) begin
    if (sys_rst) begin
      pos <= 0;
    end else if (feed) begin
      pos <= pos + 1;
    end
  end
endmodule

/* File: card_group_total_sequencer_tb_top.sv */
`timescale 1ns/1ps
`include "cgts_params.svh"
`define CGTS_CHECK(g, e) begin tests_run++; if ((g) !== (e)) begin failures++; \
  $display("mismatch at %0t: got %0h expected %0h", $time, (g), (e)); end end
module card_group_total_sequencer_tb_top;
  localparam int unsigned LC = 20;
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        listWired = 1'b1;
  logic        threeStation = 1'b0;
  logic        fastList = 1'b0;
  logic        numericOnly = 1'b0;
  logic [3:0]  qtyHole = 4'h0;
  logic [3:0]  subtract = 4'h0;
  logic [3:0]  printCmd = 4'h0;
  logic        cardAt2, cardAt3, headCard, feed, cycStrobe, barsUp, totalCycle, ctrlChange;
  logic [7:0]  ctrlAt2, ctrlAt3, idMagnets;
  logic [23:0] idHoles;
  logic [15:0] qtyDigit;
  logic [63:0] totMagnets;
  logic [75:0] evQ[$];
  int          lenQ[$];
  int          spanQ[$];
  int          spanCnt = 0;
  int          failures = 0;
  int          tests_run = 0;
  int          clkCount = 0;
  int          upCnt = 0;
  cgts_sequencer #(.LIST_CYC(LC)) dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .listWired(listWired),
    .fastList(fastList), .numericOnly(numericOnly), .threeStation(threeStation), .cardAt2(cardAt2),
    .cardAt3(cardAt3),
    .headCard(headCard), .ctrlAt2(ctrlAt2), .ctrlAt3(ctrlAt3), .idHoles(idHoles), .qtyDigit(qtyDigit),
    .qtyHole(qtyHole), .subtract(subtract), .printCmd(printCmd), .feed(feed), .cycStrobe(cycStrobe),
    .barsUp(barsUp), .totalCycle(totalCycle), .ctrlChange(ctrlChange), .idMagnets(idMagnets),
    .totMagnets(totMagnets));
  cgts_card_feed feedModel (.sys_clk(sys_clk), .sys_rst(sys_rst), .feed(feed), .cardAt2(cardAt2),
    .cardAt3(cardAt3), .headCard(headCard), .ctrlAt2(ctrlAt2), .ctrlAt3(ctrlAt3), .idHoles(idHoles),
    .qtyDigit(qtyDigit));
  always #50 sys_clk = ~sys_clk;
  // ****************
  // Cycle monitor
  // ****************
  always @(negedge sys_clk) begin
    if (!sys_rst && cycStrobe === 1'b1) begin
      evQ.push_back({totalCycle, ctrlChange, feed, barsUp, idMagnets, totMagnets});
      lenQ.push_back(upCnt);
      spanQ.push_back(spanCnt);
      upCnt = 0;
      spanCnt = 0;
    end
    spanCnt++;
    if (barsUp === 1'b1) begin
      upCnt++;
    end
  end
  always @(posedge sys_clk) begin
    clkCount++;
    if (clkCount == 20000) begin
      failures++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    if (failures == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic restart();
    sys_rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    evQ.delete();
    lenQ.delete();
    spanQ.delete();
    sys_rst = 1'b0;
  endtask
  task automatic await(input int n);
    int k;
    k = 0;
    while (evQ.size() < n && k < 2000) begin
      @(negedge sys_clk);
      k++;
    end
    repeat (3 * LC) @(negedge sys_clk);
    `CGTS_CHECK(evQ.size(), n)
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic group_run();
    logic [7:0]  ctrl [5];
    logic [3:0]  dig [5];
    logic [75:0] ev;
    logic [15:0] sum;
    int          i;
    int          j;
    ctrl = '{8'h0A, 8'h0A, 8'h0B, 8'h0B, 8'h0C};
    dig = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3};
    qtyHole = 4'b0111;
    subtract = 4'b0010;
    printCmd = 4'b1011;
    for (i = 0; i < 5; i++) begin
      feedModel.deck[i] = {1'b0, ctrl[i], 16'h0000, 8'h41 + 8'(i), dig[i]};
    end
    feedModel.count = 5;
    restart();
    await(7);
    sum = 16'h0000;
    j = 0;
    for (i = 0; i < 5; i++) begin
      ev = evQ[j++];
      sum = sum + 16'(dig[i]);
      `CGTS_CHECK(ev[75:72], 4'b0011)
      `CGTS_CHECK(ev[71:64], 8'h41 + 8'(i))
      if (i < 4 && ctrl[i] != ctrl[i+1]) begin
        ev = evQ[j++];
        `CGTS_CHECK(ev[75:72], 4'b1101)
        `CGTS_CHECK(ev[63:0], {32'h0000_0000, 16'h0000 - sum, sum})
        sum = 16'h0000;
      end
    end
    for (i = 1; i < lenQ.size(); i++) begin
      `CGTS_CHECK(lenQ[i], LC)
    end
  endtask
  task automatic indicate_run();
    logic [75:0] ev;
    int          acc;
    int          lst;
    acc = (LC * `CGTS_LIST_RATE_LO) / `CGTS_ACC_RATE;
    lst = (LC * `CGTS_LIST_RATE_LO) / `CGTS_LIST_RATE_HI;
    listWired = 1'b0;
    fastList = 1'b1;
    numericOnly = 1'b0;
    threeStation = 1'b0;
    qtyHole = 4'b0111;
    subtract = 4'b0010;
    printCmd = 4'b1011;
    feedModel.deck[0] = {1'b0, 8'h0A, 16'h0000, 8'h41, 4'h1};
    feedModel.deck[1] = {1'b0, 8'h0A, 16'h0000, 8'h42, 4'h2};
    feedModel.deck[2] = {1'b0, 8'h0B, 16'h0000, 8'h43, 4'h4};
    feedModel.count = 3;
    restart();
    await(4);
    ev = evQ[0];
    `CGTS_CHECK(ev[75:64], {4'b0011, 8'h41})
    ev = evQ[1];
    `CGTS_CHECK(ev[75:64], {4'b0010, 8'h00})
    ev = evQ[2];
    `CGTS_CHECK(ev[75:72], 4'b1101)
    `CGTS_CHECK(ev[63:0], {32'h0000_0000, 16'hFFFD, 16'h0003})
    ev = evQ[3];
    `CGTS_CHECK(ev[75:64], {4'b0011, 8'h43})
    `CGTS_CHECK(spanQ[1], lst + 1)
    `CGTS_CHECK(spanQ[2], acc)
    `CGTS_CHECK(spanQ[3], lst + 1)
  endtask
  task automatic numeric_run();
    listWired = 1'b1;
    fastList = 1'b0;
    numericOnly = 1'b1;
    threeStation = 1'b0;
    feedModel.deck[0] = {1'b0, 8'h0E, 16'h0000, 8'h31, 4'h0};
    feedModel.deck[1] = {1'b0, 8'h0E, 16'h0000, 8'h32, 4'h0};
    feedModel.count = 2;
    restart();
    await(2);
    `CGTS_CHECK(evQ[1][75:64], {4'b0011, 8'h32})
    `CGTS_CHECK(spanQ[1], (LC * `CGTS_LIST_RATE_LO) / `CGTS_ACC_RATE + 1)
  endtask
  task automatic heading_run();
    logic [7:0] hd [3];
    int         i;
    hd = '{8'h11, 8'h22, 8'h33};
    threeStation = 1'b1;
    listWired = 1'b1;
    numericOnly = 1'b0;
    feedModel.deck[0] = {1'b1, 8'h0D, 24'h33_2211, 4'h0};
    feedModel.count = 1;
    restart();
    await(3);
    for (i = 0; i < 3; i++) begin
      `CGTS_CHECK(evQ[i][72:64], {1'b1, hd[i]})
    end
  endtask
  initial begin
    group_run();
    indicate_run();
    numeric_run();
    heading_run();
    print_verdict();
  end
endmodule
